// File: src/cap_check_pkg.sv
// shared widths, capability layout, operation codes and carriers
package cap_check_pkg;
  localparam int XLEN = 64;
  localparam int MW = 14;
  localparam int EW = 6;
  localparam int CTW = 2;
  localparam int IMMW = 12;
  localparam int SIZEW = 5;
  localparam int EXP_MAX = XLEN - MW;
  localparam int CAP_BYTES = 16;
  localparam int GRAN_BITS = 4;
  localparam logic [CTW-1:0] CT_UNSEALED = 2'h0;
  localparam logic [CTW-1:0] CT_SENTRY = 2'h1;
  localparam logic [XLEN-1:0] LINK_STEP = 64'h4;

  typedef struct packed {
    logic r;
    logic w;
    logic x;
    logic c;
  } perm_type;

  typedef struct packed {
    logic tag;
    perm_type perms;
    logic [CTW-1:0] ctype;
    logic [EW-1:0] exp;
    logic [MW-1:0] base_m;
    logic [MW:0] len_m;
    logic [XLEN-1:0] addr;
  } cap_type;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_SET_BOUNDS_EXACT_REG,
    OP_SET_BOUNDS_EXACT_IMM,
    OP_SET_BOUNDS_ROUNDING,
    OP_ALIGN_MASK,
    OP_REPLACE_ADDR,
    OP_ADD_REG,
    OP_ADD_IMM,
    OP_PC_NEXT,
    OP_JUMP_LINK,
    OP_SEAL_ENTRY,
    OP_MEM_CHECK
  } cap_op_type;

  typedef enum logic [1:0] {
    ACC_READ,
    ACC_WRITE,
    ACC_EXEC
  } acc_kind_type;

  typedef struct packed {
    cap_op_type op;
    cap_type src;
    cap_type pc;
    logic [XLEN-1:0] operand;
    logic [IMMW-1:0] imm;
    logic [SIZEW-1:0] size;
    acc_kind_type kind;
    logic cap_xfer;
    logic data_tag;
    logic seal_link;
  } cap_req_type;

  typedef struct packed {
    cap_type cap;
    cap_type link;
    logic [XLEN-1:0] value;
    logic fault;
    logic tag_write;
  } cap_res_type;
endpackage

// File: src/cap_bounds_decode.sv
// expands compressed bounds of a capability relative to its address
`timescale 1ns/10ps
module cap_bounds_decode
  import cap_check_pkg::*;
(
  input cap_check_pkg::cap_type cap_in, // capability to expand
  output logic [cap_check_pkg::XLEN-1:0] base_out, // inclusive base
  output logic [cap_check_pkg::XLEN:0] top_out // exclusive top
);
  logic [6:0] span;
  logic [MW-1:0] mid;
  logic [XLEN-1:0] blk;

  always_comb begin
    // upper address bits above span are shared with the bounds
    span = 7'(cap_in.exp) + 7'(MW);
    mid = MW'(cap_in.addr >> cap_in.exp);
    blk = cap_in.addr >> span;
    // address past the block boundary: base lies one block lower
    if (mid < cap_in.base_m) begin
      blk = blk - 64'h1;
    end
    base_out = (blk << span) | (XLEN'(cap_in.base_m) << cap_in.exp);
    // top is one bit wider and never wraps
    top_out = {1'b0, base_out} + ((XLEN+1)'(cap_in.len_m) << cap_in.exp);
  end
endmodule

// File: src/cap_bounds_encode.sv
// finds the smallest exponent that covers a requested range
`timescale 1ns/10ps
module cap_bounds_encode
  import cap_check_pkg::*;
(
  input logic [cap_check_pkg::XLEN-1:0] base_in, // requested base
  input logic [cap_check_pkg::XLEN:0] len_in, // requested length
  output logic [cap_check_pkg::EW-1:0] exp_out, // chosen exponent
  output logic [cap_check_pkg::MW-1:0] base_m_out, // base mantissa
  output logic [cap_check_pkg::MW:0] len_m_out, // length mantissa
  output logic [cap_check_pkg::XLEN-1:0] base_r_out, // rounded base
  output logic [cap_check_pkg::XLEN:0] top_r_out, // rounded top
  output logic exact_out // no rounding needed
);
  logic [XLEN:0] top;
  logic [XLEN:0] mask;
  logic [XLEN:0] b;
  logic [XLEN:0] t;
  logic [XLEN:0] l;
  logic found;

  always_comb begin
    top = {1'b0, base_in} + len_in;
    found = 1'b0;
    exp_out = EW'(EXP_MAX);
    base_m_out = '0;
    len_m_out = '0;
    base_r_out = '0;
    top_r_out = '0;
    mask = '0;
    b = '0;
    t = '0;
    l = '0;
    for (int e = 0; e <= EXP_MAX; e++) begin
      mask = ((XLEN+1)'(1) << e) - (XLEN+1)'(1);
      // base rounds down, top rounds up: requested bytes stay inside
      b = {1'b0, base_in} & ~mask;
      t = (top + mask) & ~mask;
      l = t - b;
      if (!found && ((l >> e) <= ((XLEN+1)'(1) << MW))) begin
        found = 1'b1;
        exp_out = EW'(e);
        base_m_out = MW'(b >> e);
        len_m_out = (MW+1)'(l >> e);
        base_r_out = XLEN'(b);
        top_r_out = t;
      end
    end
    exact_out = (base_r_out == base_in) && (top_r_out == top);
  end
endmodule

// File: src/cap_derive_check.sv
// capability derivation, representability and access checking unit
//
// Overview of operation
// - derived tagged result never exceeds source authority
// - new base from address, length from operand
// - exact set-bounds clears tag when rounding needed
// - rounded bounds never exceed source bounds
// - bounds stored relative to address, exponent-shared
// - changed address outside representable region clears tag
// - address replace keeps tag only if bounds unchanged
// - one tag per aligned granule, aligned stores
// - representable range test is circular
// - top is one bit wider, never wraps
// - type field encodes type zero
// - unsealed capability authorizes in-bounds permitted access
// - sealed capability authorizes no memory access
// - altering sealed source clears result tag; pc-next keeps the tag of a sealed pc
// - jump-link unseals entry targets, may seal link
// - entry sealing needs no authority, type one
// - top held with extra bit; length top-base
// - every accessed byte must be within bounds
`timescale 1ns/10ps
module cap_derive_check
  import cap_check_pkg::*;
#(
  parameter int GRANULE_BYTES = 16
)(
  input wire logic clock_in, // core clock
  input wire logic sys_rst_in, // synchronous reset, active high
  input wire logic req_valid_in, // request strobe
  input cap_check_pkg::cap_req_type req_in, // request fields
  output logic res_valid_out, // result strobe, one cycle
  output cap_check_pkg::cap_res_type res_out // registered result
);
  import cap_check_pkg::*;

  if (GRANULE_BYTES != CAP_BYTES) begin : g_bad_granule
    $error("granule must equal capability width");
  end

  function automatic logic is_sealed(input cap_type c);
    is_sealed = (c.ctype != CT_UNSEALED);
  endfunction

  // circular distance from base must fit inside the region
  function automatic logic in_region(input logic [XLEN-1:0] base,
                                     input logic [EW-1:0] e,
                                     input logic [XLEN-1:0] a);
    logic [6:0] span;
    span = 7'(e) + 7'(MW);
    in_region = (((a - base) >> span) == '0);
  endfunction

  cap_type dsrc;
  logic [XLEN-1:0] src_base;
  logic [XLEN:0] src_top;
  logic [XLEN-1:0] pc_base;
  logic [XLEN:0] pc_top;
  logic [XLEN-1:0] enc_base;
  logic [XLEN:0] enc_len;
  logic [EW-1:0] enc_exp;
  logic [MW-1:0] enc_base_m;
  logic [MW:0] enc_len_m;
  logic [XLEN-1:0] enc_base_r;
  logic [XLEN:0] enc_top_r;
  logic enc_exact;
  logic [XLEN-1:0] imm_sext;
  cap_res_type next_res;
  logic next_valid;

  assign dsrc = (req_in.op == OP_PC_NEXT) ? req_in.pc : req_in.src;
  assign imm_sext = XLEN'(signed'(req_in.imm));

  cap_bounds_decode u_src_decode (
    .cap_in(dsrc),
    .base_out(src_base),
    .top_out(src_top)
  );

  cap_bounds_decode u_pc_decode (
    .cap_in(req_in.pc),
    .base_out(pc_base),
    .top_out(pc_top)
  );

  // base from the source address, length from register or immediate
  always_comb begin
    enc_base = req_in.src.addr;
    enc_len = {1'b0, req_in.operand};
    if (req_in.op == OP_SET_BOUNDS_EXACT_IMM) begin
      enc_len = (XLEN+1)'(req_in.imm);
    end
    if (req_in.op == OP_ALIGN_MASK) begin
      enc_base = '0;
    end
  end

  cap_bounds_encode u_encode (
    .base_in(enc_base),
    .len_in(enc_len),
    .exp_out(enc_exp),
    .base_m_out(enc_base_m),
    .len_m_out(enc_len_m),
    .base_r_out(enc_base_r),
    .top_r_out(enc_top_r),
    .exact_out(enc_exact)
  );

  logic [XLEN-1:0] new_addr;
  logic [XLEN-1:0] eff_addr;
  logic [XLEN:0] eff_end;
  logic perm_ok;
  logic bounds_ok;
  logic align_ok;
  logic within_src;

  always_comb begin
    new_addr = req_in.src.addr + req_in.operand;
    case (req_in.op)
      OP_REPLACE_ADDR: new_addr = req_in.operand;
      OP_ADD_IMM: new_addr = req_in.src.addr + imm_sext;
      OP_PC_NEXT: new_addr = req_in.pc.addr + req_in.operand;
      OP_JUMP_LINK: new_addr = (req_in.src.addr + imm_sext) & ~64'h1;
      default: new_addr = req_in.src.addr + req_in.operand;
    endcase
  end

  // rounded range must stay inside the source bounds
  assign within_src = (enc_base_r >= src_base) &&
                      (enc_top_r <= src_top);

  always_comb begin
    eff_addr = req_in.src.addr + req_in.operand;
    // per-byte check with a wide end that never wraps
    eff_end = {1'b0, eff_addr} + (XLEN+1)'(req_in.size);
    bounds_ok = (eff_addr >= src_base) && (eff_end <= src_top) &&
                (req_in.size != '0);
    case (req_in.kind)
      ACC_READ: perm_ok = req_in.src.perms.r;
      ACC_WRITE: perm_ok = req_in.src.perms.w;
      ACC_EXEC: perm_ok = req_in.src.perms.x;
      default: perm_ok = 1'b0;
    endcase
    // capability transfers only at naturally aligned granules
    align_ok = !req_in.cap_xfer ||
               ((eff_addr[GRAN_BITS-1:0] == '0) &&
                (req_in.size == SIZEW'(CAP_BYTES)));
  end

  always_comb begin
    next_valid = req_valid_in && (req_in.op != OP_NONE);
    next_res = '0;
    next_res.cap = req_in.src;
    case (req_in.op)
      OP_SET_BOUNDS_EXACT_REG, OP_SET_BOUNDS_EXACT_IMM,
      OP_SET_BOUNDS_ROUNDING: begin
        // bounds held as mantissas relative to the address
        next_res.cap.exp = enc_exp;
        next_res.cap.base_m = enc_base_m;
        next_res.cap.len_m = enc_len_m;
        // rounding still covers every requested byte
        next_res.cap.tag = req_in.src.tag && within_src &&
                           !is_sealed(req_in.src);
        if (req_in.op != OP_SET_BOUNDS_ROUNDING) begin
          next_res.cap.tag = next_res.cap.tag && enc_exact;
        end
        next_res.value = enc_top_r[XLEN-1:0] - enc_base_r;
      end
      OP_ALIGN_MASK: begin
        next_res.cap = '0;
        next_res.value = ~64'h0 << enc_exp;
      end
      OP_REPLACE_ADDR, OP_ADD_REG, OP_ADD_IMM: begin
        next_res.cap.addr = new_addr;
        // same decoded bounds only inside the representable region
        next_res.cap.tag = req_in.src.tag &&
                           in_region(src_base, req_in.src.exp,
                                     new_addr) &&
                           (!is_sealed(req_in.src) ||
                            new_addr == req_in.src.addr);
      end
      OP_PC_NEXT: begin
        next_res.cap = req_in.pc;
        next_res.cap.addr = new_addr;
        next_res.cap.tag = req_in.pc.tag &&
                           in_region(src_base, req_in.pc.exp,
                                     new_addr);
      end
      OP_JUMP_LINK: begin
        next_res.cap.addr = new_addr;
        next_res.cap.tag = req_in.src.tag &&
                           in_region(src_base, req_in.src.exp, new_addr);
        // entry targets unseal on the jump, only at offset zero
        if (req_in.src.ctype == CT_SENTRY) begin
          next_res.cap.ctype = CT_UNSEALED;
          next_res.cap.tag = next_res.cap.tag &&
                             (new_addr == (req_in.src.addr & ~64'h1));
        end else if (is_sealed(req_in.src)) begin
          next_res.cap.tag = 1'b0;
        end
        next_res.link = req_in.pc;
        next_res.link.addr = req_in.pc.addr + LINK_STEP;
        next_res.link.tag = req_in.pc.tag &&
                            in_region(pc_base, req_in.pc.exp,
                                      req_in.pc.addr + LINK_STEP);
        if (req_in.seal_link) begin
          next_res.link.ctype = CT_SENTRY;
        end
        next_res.value = 64'(pc_top[XLEN-1:0]);
      end
      OP_SEAL_ENTRY: begin
        // ambient type: no authorizing capability consulted
        next_res.cap.ctype = CT_SENTRY;
        next_res.cap.tag = req_in.src.tag && !is_sealed(req_in.src);
      end
      OP_MEM_CHECK: begin
        // tagged, unsealed, permitted, in bounds, aligned
        next_res.fault = !req_in.src.tag || !perm_ok ||
                         is_sealed(req_in.src) ||
                         !bounds_ok || !align_ok;
        // tag written with the data; set only by a permitted store
        next_res.tag_write = (req_in.kind == ACC_WRITE) &&
                             req_in.cap_xfer && req_in.data_tag &&
                             req_in.src.perms.c &&
                             !next_res.fault;
        next_res.value = eff_addr >> GRAN_BITS;
        next_res.cap = '0;
      end
      default: begin
        next_res.cap = '0;
      end
    endcase
    // no output tag without a tagged source
    if (!req_in.src.tag && req_in.op != OP_PC_NEXT) begin
      next_res.cap.tag = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      res_valid_out <= 1'b0;
    end else begin
      res_valid_out <= next_valid;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      res_out <= '0;
    end else if (next_valid) begin
      res_out <= next_res;
    end
  end
endmodule

// File: testbench/cap_pipe_model.sv
// pipeline model that issues capability requests
`timescale 1ns/10ps
module cap_pipe_model
  import cap_check_pkg::*;
(
  input wire logic clock_in, // core clock
  input wire logic issue_in, // issue the pending request
  input cap_check_pkg::cap_req_type req_next_in, // pending request
  output logic req_valid_out, // request strobe
  output cap_check_pkg::cap_req_type req_out // request fields
);
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end
  // idle fields are scrambled so stale values are never trusted
  always @(negedge clock_in) begin
    req_valid_out <= issue_in;
    req_out <= issue_in ? req_next_in : ~req_out;
  end
endmodule

// File: testbench/cap_derive_check_assertions.sv
// assertions on the ports of the capability derivation unit
`timescale 1ns/10ps
module cap_check_sva
  import cap_check_pkg::*;
#(
  parameter int GRANULE_BYTES = 16
)(
  input wire logic clock_in, // core clock
  input wire logic sys_rst_in, // synchronous reset
  input wire logic req_valid_in, // request strobe
  input cap_check_pkg::cap_req_type req_in, // request fields
  input wire logic res_valid_out, // result strobe
  input cap_check_pkg::cap_res_type res_out // result
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire tk = req_valid_in && req_in.op != OP_NONE;
  a_answer_next: assert property (tk |=> res_valid_out)
    else $error("no result one cycle after request");
  a_no_answer: assert property (
    !tk |=> !res_valid_out && $stable(res_out))
    else $error("result without request");
  a_untagged_src: assert property (
    tk && req_in.op != OP_PC_NEXT && !req_in.src.tag
    |=> !res_out.cap.tag)
    else $error("tag made from untagged source");
  a_exact_len: assert property (
    tk && req_in.op == OP_SET_BOUNDS_EXACT_REG
    |=> !res_out.cap.tag || res_out.value == $past(req_in.operand))
    else $error("exact bounds tagged but rounded");
  a_imm_len: assert property (
    tk && req_in.op == OP_SET_BOUNDS_EXACT_IMM &&
    req_in.src.ctype == CT_UNSEALED
    |=> res_out.value == {52'h0, $past(req_in.imm)})
    else $error("immediate length wrong");
  a_round_cover: assert property (
    tk && req_in.op == OP_SET_BOUNDS_ROUNDING
    |=> res_out.value >= $past(req_in.operand))
    else $error("rounded length below request");
  a_sealed_access: assert property (
    tk && req_in.op == OP_MEM_CHECK && req_in.src.ctype != CT_UNSEALED
    |=> res_out.fault)
    else $error("sealed capability granted access");
  a_sealed_alter: assert property (
    tk && req_in.op == OP_ADD_IMM &&
    req_in.src.ctype != CT_UNSEALED && req_in.imm != 12'h0
    |=> !res_out.cap.tag)
    else $error("altered sealed capability kept tag");
  a_seal_ambient: assert property (
    tk && req_in.op == OP_SEAL_ENTRY &&
    req_in.src.tag && req_in.src.ctype == CT_UNSEALED
    |=> res_out.cap.tag && res_out.cap.ctype == CT_SENTRY)
    else $error("entry sealing failed");
  a_misaligned: assert property (
    tk && req_in.op == OP_MEM_CHECK && req_in.cap_xfer &&
    req_in.src.addr[3:0] + req_in.operand[3:0] != 4'h0
    |=> res_out.fault)
    else $error("misaligned capability transfer allowed");
  a_fault_no_tag: assert property (
    res_valid_out && res_out.fault |-> !res_out.tag_write)
    else $error("tag written on faulting access");
  c_tag_write: cover property (res_valid_out && res_out.tag_write);
  c_fault: cover property (res_valid_out && res_out.fault);
  c_round: cover property (tk && req_in.op == OP_SET_BOUNDS_ROUNDING);
endmodule
bind cap_derive_check cap_check_sva #(.GRANULE_BYTES(GRANULE_BYTES)) u_sva (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .req_valid_in(req_valid_in), .req_in(req_in),
  .res_valid_out(res_valid_out), .res_out(res_out));

// File: testbench/testbench.sv
// self-checking bench for the capability derivation unit
`timescale 1ns/10ps
module testbench;
  import cap_check_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic go = 1'b0;
  logic rv;
  logic qv;
  cap_req_type pend = '0;
  cap_req_type q;
  cap_res_type res;
  cap_type root, b, s;
  int errors = 0;
  int comparisons = 0;
  logic [15:0] lf = 16'h19;
  logic [63:0] o;
  logic [4:0] z;
  always #2.5 clock_in = ~clock_in;
  cap_pipe_model u_pipe (.clock_in(clock_in), .issue_in(go),
    .req_next_in(pend), .req_valid_out(qv), .req_out(q));
  cap_derive_check #(.GRANULE_BYTES(16)) u_dut (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .req_valid_in(qv), .req_in(q),
    .res_valid_out(rv), .res_out(res));
  task automatic close_out();
    $display("compared %0d, failed %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %0b got %0b", n, e, g);
    end
  endtask
  task automatic chk_word(string n, logic [63:0] e, logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
    end
  endtask
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic inb(logic [63:0] off, logic [4:0] sz,
                               logic [63:0] len);
    return sz != 5'h0 && {1'b0, off} + sz <= {1'b0, len};
  endfunction
  task automatic run(cap_op_type op, cap_type c, logic [63:0] opd);
    int n;
    @(posedge clock_in);
    pend.op = op;
    pend.src = c;
    pend.operand = opd;
    go = 1'b1;
    @(posedge clock_in);
    go = 1'b0;
    for (n = 0; n < 4 && rv !== 1'b1; n++) @(negedge clock_in);
    chk_bit("answer", 1'b1, rv);
  endtask
  initial begin
    #25000;
    errors++;
    close_out();
  end
  initial begin
    root = '0;
    root.tag = 1'b1;
    root.perms = '1;
    root.exp = 6'd50;
    root.len_m = 15'h4000;
    repeat (8) @(negedge clock_in);
    sys_rst_in = 1'b0;
    chk_bit("rst valid", 1'b0, rv);
    chk_word("rst value", 64'h0, res.value);
    root.addr = 64'h1000;
    run(OP_SET_BOUNDS_EXACT_REG, root, 64'h100);
    b = res.cap;
    chk_bit("exact tag", 1'b1, b.tag);
    chk_word("length", 64'h100, res.value);
    chk_word("type zero", 64'h0, {62'h0, b.ctype});
    pend.imm = 12'hfff;
    run(OP_SET_BOUNDS_EXACT_IMM, b, 64'h0);
    chk_bit("grow tag", 1'b0, res.cap.tag);
    pend.imm = 12'h40;
    run(OP_SET_BOUNDS_EXACT_IMM, b, 64'h0);
    chk_word("imm length", 64'h40, res.value);
    root.addr = 64'h2000;
    run(OP_SET_BOUNDS_EXACT_REG, root, 64'h8000);
    s = res.cap;
    s.addr = 64'h2001;
    run(OP_SET_BOUNDS_EXACT_REG, s, 64'h7fff);
    chk_bit("inexact tag", 1'b0, res.cap.tag);
    run(OP_SET_BOUNDS_ROUNDING, s, 64'h7fff);
    chk_bit("round tag", 1'b1, res.cap.tag);
    chk_bit("round cover", 1'b1, res.value >= 64'h7fff);
    run(OP_SET_BOUNDS_ROUNDING, s, 64'h8000);
    chk_bit("round over", 1'b0, res.cap.tag);
    $display("bounds tests done");
    run(OP_ALIGN_MASK, root, 64'h8000);
    chk_word("align mask", 64'hffff_ffff_ffff_fffe, res.value);
    run(OP_REPLACE_ADDR, b, 64'h4fff);
    chk_bit("in region", 1'b1, res.cap.tag);
    chk_word("new addr", 64'h4fff, res.cap.addr);
    run(OP_REPLACE_ADDR, b, 64'h5000);
    chk_bit("out region", 1'b0, res.cap.tag);
    run(OP_ADD_REG, b, 64'h4000);
    chk_bit("add out", 1'b0, res.cap.tag);
    pend.imm = 12'hfff;
    run(OP_ADD_IMM, b, 64'h0);
    chk_bit("add back", 1'b0, res.cap.tag);
    pend.pc = b;
    run(OP_PC_NEXT, root, 64'h4);
    chk_bit("pc step", 1'b1, res.cap.tag);
    run(OP_PC_NEXT, root, 64'h4000);
    chk_bit("pc leave", 1'b0, res.cap.tag);
    root.addr = 64'hffff_ffff_ffff_fff0;
    run(OP_SET_BOUNDS_EXACT_REG, root, 64'h10);
    s = res.cap;
    run(OP_ADD_REG, s, 64'h10);
    chk_bit("wrap region", 1'b1, res.cap.tag);
    pend.size = 5'h1;
    pend.kind = ACC_READ;
    run(OP_MEM_CHECK, s, 64'h10);
    chk_bit("no wrap top", 1'b1, res.fault);
    run(OP_MEM_CHECK, s, 64'hf);
    chk_bit("last byte", 1'b0, res.fault);
    $display("address tests done");
    run(OP_SEAL_ENTRY, b, 64'h0);
    s = res.cap;
    chk_bit("sealed", 1'b1, s.tag && s.ctype === CT_SENTRY);
    run(OP_MEM_CHECK, s, 64'h0);
    chk_bit("sealed use", 1'b1, res.fault);
    pend.imm = 12'h4;
    run(OP_ADD_IMM, s, 64'h0);
    chk_bit("sealed add", 1'b0, res.cap.tag);
    pend.imm = 12'h0;
    pend.seal_link = 1'b1;
    run(OP_JUMP_LINK, s, 64'h0);
    chk_bit("unseal", 1'b1, res.cap.tag && res.cap.ctype === 2'h0);
    chk_word("link addr", 64'h1004, res.link.addr);
    s = res.link;
    chk_bit("link sealed", 1'b1, s.tag && s.ctype === CT_SENTRY);
    pend.seal_link = 1'b0;
    pend.kind = ACC_WRITE;
    pend.cap_xfer = 1'b1;
    pend.data_tag = 1'b1;
    pend.size = 5'h10;
    run(OP_MEM_CHECK, b, 64'h10);
    chk_bit("tag store", 1'b1, res.tag_write);
    chk_word("granule", 64'h101, res.value);
    run(OP_MEM_CHECK, b, 64'h18);
    chk_bit("misalign", 1'b1, res.fault);
    pend.cap_xfer = 1'b0;
    s = b;
    s.perms.w = 1'b0;
    run(OP_MEM_CHECK, s, 64'h0);
    chk_bit("no write perm", 1'b1, res.fault);
    pend.kind = ACC_READ;
    $display("seal and granule tests done");
    repeat (40) begin
      lf = nx(lf);
      o = {55'h0, lf[8:0]};
      z = lf[15:11];
      pend.size = z;
      run(OP_MEM_CHECK, b, o);
      chk_bit("rand bounds", !inb(o, z, 64'h100), res.fault);
    end
    $display("random tests done");
    close_out();
  end
endmodule
